// ===== hdl/temon_pkg.sv
package temon_pkg;
  // parameter addresses, kept as the printed register offsets
  localparam logic [15:0] ADDR_PEAK = 16'h111e;
  localparam logic [15:0] ADDR_LIMIT = 16'h121c;
  localparam logic [15:0] ADDR_NOW = 16'h1e24;
  localparam logic [31:0] LIMIT_RESET = 32'h0000_2710;
  localparam logic [31:0] LIMIT_MIN = 32'h0000_0001;
  localparam logic [31:0] LIMIT_MAX = 32'h001e_8480;
  localparam logic [31:0] PEAK_RESET = 32'h0000_0000;
  localparam int CLK_HZ = 40000000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
endpackage : temon_pkg

// ===== hdl/temon_tick.sv
`timescale 1ns/1ps
`default_nettype none
// one-cycle pulse every millisecond
module temon_tick (
  input wire logic sys_clk_in, // clock
  input wire logic rst_in, // sync reset
  output logic tick_out // 1 ms pulse
);
  logic [15:0] count;
  wire logic wrap = (count == temon_pkg::TICK_LAST);
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      count <= 16'h0000;
      tick_out <= 1'b0;
    end else begin
      count <= wrap ? 16'h0000 : count + 16'h0001; // RULE12
      tick_out <= wrap;
    end
  end
endmodule : temon_tick
`default_nettype wire

// ===== hdl/temon_top.sv
// Operation
// [RULE1] compare only torque-producing deviation part
// [RULE2] error is offset minus velocity-dependent offset
// [RULE3] operator derives minimum limit from gains
// [RULE4] operator uses current ceiling as reference
// [RULE5] derivation uses proportional path only
// [RULE6] reaching limit flags error, stops motion
// [RULE7] operator sets limit five times minimum
// [RULE8] unsigned 32-bit peak value readable
// [RULE9] any write clears stored peak
// [RULE10] report signed present deviation read-only
// [RULE11] limit 1..2000000, default 10000, read-write
// [RULE12] evaluate once every millisecond
// [RULE13] tick updates peak when magnitude larger
`timescale 1ns/1ps
`default_nettype none
module temon_top (
  input wire logic sys_clk_in, // clock 40 MHz
  input wire logic rst_in, // sync reset, active high
  input wire logic [31:0] pos_offset_in, // position regulation offset
  input wire logic [31:0] vel_offset_in, // velocity-dependent offset
  input wire logic reg_wr_in, // parameter write strobe
  input wire logic reg_rd_in, // parameter read strobe
  input wire logic [15:0] reg_addr_in, // parameter address
  input wire logic [31:0] reg_wdata_in, // write data
  input wire logic fault_ack_in, // clears tracking error flag
  output logic [31:0] reg_rdata_out, // read data
  output logic reg_rvalid_out, // read data valid
  output logic reg_err_out, // unmapped or rejected access
  output logic [31:0] deviation_now_out, // present deviation
  output logic tracking_error_out, // tracking error latched
  output logic motion_stop_out // shut down movement
);
  logic tick;
  logic [31:0] deviation_now;
  logic [31:0] deviation_peak_hold;
  logic [31:0] deviation_trip_limit;
  logic [31:0] next_peak;

  temon_tick u_tick (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .tick_out(tick)
  );

  // torque part only: feed-forward share removed
  wire logic [31:0] torque_dev = pos_offset_in - vel_offset_in; // RULE1 RULE2
  wire logic [31:0] dev_mag = torque_dev[31] ? (32'h0000_0000 - torque_dev) : torque_dev;
  wire logic peak_grow = tick && (dev_mag > deviation_peak_hold); // RULE13
  wire logic trip = tick && (dev_mag >= deviation_trip_limit); // RULE6

  wire logic hit_peak = (reg_addr_in == temon_pkg::ADDR_PEAK);
  wire logic hit_limit = (reg_addr_in == temon_pkg::ADDR_LIMIT);
  wire logic hit_now = (reg_addr_in == temon_pkg::ADDR_NOW);
  wire logic mapped = hit_peak || hit_limit || hit_now;
  wire logic limit_ok = (reg_wdata_in >= temon_pkg::LIMIT_MIN) && (reg_wdata_in <= temon_pkg::LIMIT_MAX);
  wire logic limit_wr = reg_wr_in && hit_limit && limit_ok; // RULE11
  wire logic peak_clr = reg_wr_in && hit_peak; // RULE9
  wire logic wr_bad = reg_wr_in && (!mapped || hit_now || (hit_limit && !limit_ok));
  wire logic rd_bad = reg_rd_in && !mapped;
  wire logic [31:0] rd_mux = hit_peak ? deviation_peak_hold :
                             hit_limit ? deviation_trip_limit :
                             hit_now ? deviation_now : 32'h0000_0000;

  // clear wins over a same-cycle grow: the write is the later event
  always_comb begin
    next_peak = deviation_peak_hold;
    if (peak_grow) begin
      next_peak = dev_mag; // RULE8 RULE13
    end
    if (peak_clr) begin
      next_peak = temon_pkg::PEAK_RESET; // RULE9
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      deviation_peak_hold <= temon_pkg::PEAK_RESET;
      deviation_trip_limit <= temon_pkg::LIMIT_RESET;
      deviation_now <= 32'h0000_0000;
    end else begin
      deviation_peak_hold <= next_peak;
      if (limit_wr) begin
        deviation_trip_limit <= reg_wdata_in; // RULE11
      end
      if (tick) begin
        deviation_now <= torque_dev; // RULE10 RULE12
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      tracking_error_out <= 1'b0;
      motion_stop_out <= 1'b0;
    end else if (trip) begin
      tracking_error_out <= 1'b1; // RULE6
      motion_stop_out <= 1'b1; // RULE6
    end else if (fault_ack_in) begin
      tracking_error_out <= 1'b0;
      motion_stop_out <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
      reg_rvalid_out <= 1'b0;
      reg_err_out <= 1'b0;
      deviation_now_out <= 32'h0000_0000;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0000_0000; // RULE8 RULE10
      reg_rvalid_out <= reg_rd_in && mapped;
      reg_err_out <= wr_bad || rd_bad;
      deviation_now_out <= deviation_now;
    end
  end
endmodule : temon_top
`default_nettype wire

// ===== tb/temon_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module temon_monitor (
  input wire logic sys_clk_in, rst_in, reg_wr_in, reg_rd_in, fault_ack_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in, reg_rdata_out,
  input wire logic reg_rvalid_out, reg_err_out, tracking_error_out, motion_stop_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  wire lim = reg_addr_in == 16'h121c;
  wire okv = reg_wdata_in != 0 && reg_wdata_in <= 32'h1e8480;
  wire map = lim || reg_addr_in == 16'h111e || reg_addr_in == 16'h1e24;
  sequence clr_pk; reg_wr_in && reg_addr_in == 16'h111e; endsequence
  sequence rd_pk; reg_rd_in && reg_addr_in == 16'h111e; endsequence
  a_read_valid: assert property (reg_rd_in && map |=> reg_rvalid_out) else $error("rvalid missing");
  a_no_rvalid: assert property (!reg_rd_in |=> !reg_rvalid_out) else $error("rvalid spurious");
  a_peak_clear: assert property (clr_pk ##[1:2] rd_pk |=> reg_rdata_out == 0) else $error("peak kept");
  a_limit_refuse: assert property (reg_wr_in && lim && !okv |=> reg_err_out) else $error("bad limit taken");
  a_limit_accept: assert property (reg_wr_in && lim && okv && !reg_rd_in |=> !reg_err_out) else $error("limit err");
  a_now_readonly: assert property (reg_wr_in && reg_addr_in == 16'h1e24 |=> reg_err_out) else $error("now written");
  a_stop_flag: assert property (motion_stop_out == tracking_error_out) else $error("stop differs");
  a_flag_sticky: assert property (tracking_error_out && !fault_ack_in |=> tracking_error_out) else $error("flag lost");
endmodule : temon_monitor
bind temon_top temon_monitor chk_i (.*);
`default_nettype wire

// ===== tb/temon_master.sv
`timescale 1ns/1ps
`default_nettype none
module temon_master (
  input wire logic clk_in, // clock
  output logic wr_out, rd_out, // strobes
  output logic [15:0] addr_out, // address
  output logic [31:0] data_out // write data
);
  initial {wr_out, rd_out, addr_out, data_out} = '0;
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_out <= a;
    data_out <= d;
    if (w) wr_out <= 1; else rd_out <= 1;
    @(posedge clk_in);
    {wr_out, rd_out} <= 2'h0;
    data_out <= ~d; // released lines do not keep the word
  endtask : xfer
endmodule : temon_master
`default_nettype wire

// ===== tb/temon_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module temon_top_test;
  logic sys_clk_in, rst_in, fault_ack_in;
  logic [31:0] pos_offset_in, vel_offset_in, seed, dev, q[$];
  wire reg_wr_in, reg_rd_in, reg_rvalid_out, reg_err_out, tracking_error_out, motion_stop_out;
  wire [15:0] reg_addr_in;
  wire [31:0] reg_wdata_in, reg_rdata_out, deviation_now_out;
  int errors = 0, total_checks = 0, cyc = 0;
  localparam logic [31:0] MIN_DEV = 32'h1a0;
  temon_top uut (.*);
  temon_master m (.clk_in(sys_clk_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in), .addr_out(reg_addr_in),
    .data_out(reg_wdata_in));
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin errors++; $display("[ERR] %s exp %h got %h", n, e, g); end
  endtask : chk
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    q.push_back(e);
    m.xfer(0, a, 0);
  endtask : rd
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  always @(posedge sys_clk_in) begin
    cyc++;
    if (reg_rvalid_out === 1'b1) chk("rdata", q.size() ? q.pop_front() : 'x, reg_rdata_out);
    if (cyc == 90000) begin errors++; report_and_stop(); end
  end
  initial begin sys_clk_in = 0; forever #12.5 sys_clk_in = ~sys_clk_in; end
  initial begin
    {seed, rst_in, fault_ack_in, pos_offset_in, vel_offset_in} = {32'h25a2, 1'b1, 65'h0};
    repeat (5) @(posedge sys_clk_in);
    rst_in <= 0;
    rd(16'h121c, 32'h2710);
    rd(16'h111e, 0);
    m.xfer(1, 16'h121c, 0);
    m.xfer(1, 16'h121c, 32'h1e8481);
    m.xfer(1, 16'h1e24, 5);
    m.xfer(1, 16'h121c, 5 * MIN_DEV);
    rd(16'h121c, 32'h820);
    dev = 32'd1000 + ($random(seed) & 32'h3ff);
    pos_offset_in <= seed + dev;
    vel_offset_in <= seed;
    repeat (40000) @(posedge sys_clk_in);
    rd(16'h1e24, dev);
    rd(16'h111e, dev);
    chk("trip", 0, tracking_error_out);
    chk("now_out", dev, deviation_now_out);
    m.xfer(1, 16'h111e, $random(seed));
    rd(16'h111e, 0);
    vel_offset_in <= pos_offset_in + 32'd3000;
    repeat (40000) @(posedge sys_clk_in);
    rd(16'h1e24, -32'sd3000);
    rd(16'h111e, 32'd3000);
    chk("trip", 1, tracking_error_out);
    chk("stop", 1, motion_stop_out);
    chk("now_out", -32'sd3000, deviation_now_out);
    vel_offset_in <= pos_offset_in;
    fault_ack_in <= 1'b1;
    @(posedge sys_clk_in);
    fault_ack_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    chk("trip", 0, tracking_error_out);
    chk("stop", 0, motion_stop_out);
    repeat (3) @(posedge sys_clk_in);
    report_and_stop();
  end
endmodule : temon_top_test
`default_nettype wire
